/* hdl/fdt_chan_loop.sv */
/*
 Fan-start threshold adjuster for one temperature channel.
 Assumes temp_i is a raw code with two fraction bits, sampled on mon_i.
*/
`timescale 1ns/10ps
module fdt_chan_loop #(
	parameter int TW = fdt_pkg::TW
) (
	input logic clk_i,
	input logic rst_i,
	input logic mon_i,
	input logic short_i,
	input logic long_i,
	input logic en_i,
	input logic [TW+1:0] temp_i,
	input logic [TW-1:0] target_i,
	input logic [3:0] hyst_i,
	input logic [TW-1:0] low_i,
	input logic wr_i,
	input logic [TW-1:0] wr_data_i,
	output logic [TW-1:0] thr_o
);
	import fdt_pkg::*;
	if (TW < 5) begin : g_chk
		$error("Temperature width too small");
	end
	logic [TW+1:0] prev_reg;
	logic [TW-1:0] thr_reg;
	logic [TW-1:0] tint;
	logic [TW-1:0] hy;
	logic [TW-1:0] band;
	logic [TW+1:0] rise;
	logic [TW:0] dec;
	logic above_band;
	logic above_op;
	logic below_low;
	assign tint = temp_i[TW+1:2];
	assign hy = TW'(hyst_i);
	assign band = (target_i > hy) ? target_i - hy : '0;
	assign above_band = tint > band;
	assign above_op = tint > target_i;
	assign below_low = tint < low_i;
	assign rise = temp_i - prev_reg;
	assign thr_o = thr_reg;
	always_comb begin
		dec = '0;
		// Quarter-degree rise units, halved: two degrees per degree risen
		if (short_i && above_band && temp_i > prev_reg && rise >= (TW+2)'(RISE_MIN_Q)) begin
			dec = rise[TW+1:1];
		end
		if (long_i && above_op) begin
			dec = dec + 1'b1;
		end
	end
	// Reset to the top code so the first sample never looks like a rise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_reg <= '1;
		end else if (mon_i) begin
			prev_reg <= temp_i;
		end
	end
	// Software write wins over a same-cycle adjustment
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			thr_reg <= TW'(THR_RST);
		end else if (wr_i) begin
			thr_reg <= wr_data_i;
		end else if (en_i && dec != '0) begin
			thr_reg <= ({1'b0, thr_reg} > dec) ? thr_reg - dec[TW-1:0] : '0;
		end else if (en_i && long_i && below_low && thr_reg != '1) begin
			thr_reg <= thr_reg + 1'b1;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	raise_step_a: assert property (en_i && long_i && below_low && !above_op && !wr_i
		&& dec == '0 && thr_reg != '1 |=> thr_reg == $past(thr_reg) + 1'b1)
		else $error("Threshold not raised by one");
	raise_cause_a: assert property (!wr_i ##1 thr_reg > $past(thr_reg)
		|-> $past(long_i) && $past(below_low))
		else $error("Threshold raised outside a long cycle");
	lower_cause_a: assert property (!wr_i ##1 thr_reg < $past(thr_reg)
		|-> $past(short_i) && ($past(above_band) || $past(above_op)))
		else $error("Threshold lowered without cause");
	no_wrap_a: assert property (thr_reg == '0 && !wr_i |=> thr_reg <= TW'(1))
		else $error("Threshold wrapped below zero");
	hold_off_a: assert property (!en_i && !wr_i |=> $stable(thr_reg))
		else $error("Threshold moved while disabled");
endmodule

/* hdl/fdt_cycle_timer.sv */
/*
 Monitoring-cycle divider for one channel: short and long adjustment ticks.
 Assumes mon_i is a one-cycle pulse per completed monitoring cycle.
*/
`timescale 1ns/10ps
module fdt_cycle_timer #(
	parameter int CW = fdt_pkg::CODE_W,
	parameter int NW = fdt_pkg::CNT_W
) (
	input logic clk_i,
	input logic rst_i,
	input logic mon_i,
	input logic [CW-1:0] code_i,
	output logic short_o,
	output logic long_o
);
	import fdt_pkg::*;
	localparam logic [NW-1:0] ONES = '1;
	if (NW < (2 ** CW) - 1 + LONG_LOG2) begin : g_chk
		$error("Counter too narrow for cycle codes");
	end
	logic [NW-1:0] cnt_reg;
	logic [NW-1:0] cnt_next;
	logic [NW-1:0] smask;
	logic [NW-1:0] lmask;
	assign cnt_next = cnt_reg + 1'b1;
	assign smask = ~(ONES << (5'(code_i) + 5'(SHORT_LOG2)));
	assign lmask = ~(ONES << (5'(code_i) + 5'(LONG_LOG2)));
	// Short every n, long every 2n monitoring cycles
	assign short_o = mon_i && ((cnt_next & smask) == '0);
	assign long_o = mon_i && ((cnt_next & lmask) == '0);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
		end else if (mon_i) begin
			cnt_reg <= cnt_next;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	long_has_short_a: assert property (long_o |-> short_o)
		else $error("Long tick without short tick");
	short_on_mon_a: assert property (short_o |=> cnt_reg[SHORT_LOG2-1:0] == '0)
		else $error("Short tick off a monitoring cycle");
endmodule

/* hdl/fdt_dyn_thresh.sv */
/*
 Dynamic fan-start threshold loop with Wishbone classic register slave.
 Assumes temperature samples arrive with a one-cycle valid per monitoring
 cycle and that the fan PWM loop consumes thresholds and fan-on levels.
*/
// Design decision made here: the Wishbone register port.
// Functional notes
// - Adjust each channel's fan-start threshold from its measured temperature.
// - Three separate target registers, each regulating its own zone.
// - Targets are 8-bit, one degree per code step.
// - Targets at consecutive indices, each resetting to the 100 degree code.
// - Temperature below low limit: raise threshold so fans stay off longer.
// - Temperature above target: lower threshold so fans start earlier.
// - Each zone is adjusted independently of the others.
// - Below low limit sets a status flag.
// - Above high limit sets a status flag.
// - Fan starts when temperature reaches the fan-start threshold.
// - Above critical limit, fans run at full duty.
// - Per-channel span setting sets duty slope above threshold.
// - Short tick every n, long every 2n cycles; 3-bit code picks n.
// - Each long cycle above target lowers threshold one more degree.
// - Above target minus hysteresis, short cycle lowers by twice the rise.
// - Raise only in long cycle and only below the low limit.
`timescale 1ns/10ps
module fdt_dyn_thresh (
	input logic clk_i,
	input logic rst_i,
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [3:0] wb_sel_i,
	input logic [fdt_pkg::ADR_W-1:0] wb_adr_i,
	input logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input logic temp_valid_i,
	input logic [fdt_pkg::TW+1:0] remote1_temp_i,
	input logic [fdt_pkg::TW+1:0] local_temp_i,
	input logic [fdt_pkg::TW+1:0] remote2_temp_i,
	output logic [fdt_pkg::TW-1:0] remote1_fan_start_threshold_o,
	output logic [fdt_pkg::TW-1:0] local_fan_start_threshold_o,
	output logic [fdt_pkg::TW-1:0] remote2_fan_start_threshold_o,
	output logic [fdt_pkg::TW-1:0] remote1_duty_slope_span_o,
	output logic [fdt_pkg::TW-1:0] local_duty_slope_span_o,
	output logic [fdt_pkg::TW-1:0] remote2_duty_slope_span_o,
	output logic [fdt_pkg::NCH-1:0] fan_on_o,
	output logic full_speed_o
);
	import fdt_pkg::*;

	if (NCH != 3 || TW != 8) begin : g_chk
		$error("Register map serves three 8-bit channels only");
	end

	logic ack_reg;
	logic [31:0] rdat_reg;
	logic [31:0] rd_mux;
	logic req;
	logic adr_ok;
	logic wr;
	logic [IDX_W-1:0] idx;

	logic [TW-1:0] tgt_reg [NCH];
	logic [TW-1:0] low_temp_limit_reg [NCH];
	logic [TW-1:0] high_temp_limit_reg [NCH];
	logic [TW-1:0] critical_temp_limit_reg [NCH];
	logic [TW-1:0] duty_slope_span_reg [NCH];
	logic [7:0] hya_reg;
	logic [7:0] hyb_reg;
	logic [2:0] ctrl_reg;
	logic [8:0] cyc_reg;
	logic [8:0] stat_reg;
	logic [8:0] stat_next;
	logic [8:0] stat_set;
	logic [8:0] stat_clr;
	logic [NCH-1:0] crit_act_reg;
	logic [NCH-1:0] fan_on_reg;

	logic [TW+1:0] temp [NCH];
	logic [TW-1:0] tint [NCH];
	logic [3:0] hy [NCH];
	logic [TW-1:0] thr [NCH];
	logic [TW-1:0] crit_band [NCH];
	logic [NCH-1:0] short_tick;
	logic [NCH-1:0] long_tick;
	logic [NCH-1:0] thr_wr;

	assign temp[0] = remote1_temp_i;
	assign temp[1] = local_temp_i;
	assign temp[2] = remote2_temp_i;
	assign hy[0] = hya_reg[7:4];
	assign hy[1] = hya_reg[3:0];
	assign hy[2] = hyb_reg[7:4];

	// Bus slave: one wait state, write lands on the edge that sees ack
	assign req = wb_cyc_i && wb_stb_i;
	assign idx = wb_adr_i[IDX_W+IDX_LSB-1:IDX_LSB];
	assign adr_ok = (wb_adr_i[ADR_W-1:IDX_W+IDX_LSB] == '0);
	assign wr = req && wb_we_i && ack_reg && adr_ok;
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req && !ack_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_reg <= 32'h0000_0000;
		end else if (req && !ack_reg) begin
			rdat_reg <= rd_mux;
		end
	end

	// Unmapped addresses read zero and ignore writes
	always_comb begin
		rd_mux = 32'h0000_0000;
		for (int c = 0; c < NCH; c++) begin
			if (idx == TGT_IDX[c]) begin
				rd_mux[TW-1:0] = tgt_reg[c];
			end
			if (idx == LOW_IDX[c]) begin
				rd_mux[TW-1:0] = low_temp_limit_reg[c];
			end
			if (idx == HIGH_IDX[c]) begin
				rd_mux[TW-1:0] = high_temp_limit_reg[c];
			end
			if (idx == CRIT_IDX[c]) begin
				rd_mux[TW-1:0] = critical_temp_limit_reg[c];
			end
			if (idx == SPAN_IDX[c]) begin
				rd_mux[TW-1:0] = duty_slope_span_reg[c];
			end
			if (idx == THR_IDX[c]) begin
				rd_mux[TW-1:0] = thr[c];
			end
		end
		if (idx == CTRL_IDX) begin
			rd_mux[2:0] = ctrl_reg;
		end
		if (idx == CYC_IDX) begin
			rd_mux[8:0] = cyc_reg;
		end
		if (idx == STAT_IDX) begin
			rd_mux[8:0] = stat_reg;
		end
		if (idx == HYA_IDX) begin
			rd_mux[7:0] = hya_reg;
		end
		if (idx == HYB_IDX) begin
			rd_mux[7:4] = hyb_reg[7:4];
		end
		if (!adr_ok) begin
			rd_mux = 32'h0000_0000;
		end
	end

	// Target registers, one per zone
	always_ff @(posedge clk_i) begin
		for (int c = 0; c < NCH; c++) begin
			if (rst_i) begin
				tgt_reg[c] <= TGT_RST;
			end else if (wr && wb_sel_i[0] && idx == TGT_IDX[c]) begin
				tgt_reg[c] <= wb_dat_i[TW-1:0];
			end
		end
	end

	// Limit and slope registers
	always_ff @(posedge clk_i) begin
		for (int c = 0; c < NCH; c++) begin
			if (rst_i) begin
				low_temp_limit_reg[c] <= LOW_RST;
				high_temp_limit_reg[c] <= HIGH_RST;
				critical_temp_limit_reg[c] <= CRIT_RST;
				duty_slope_span_reg[c] <= SPAN_RST;
			end else if (wr && wb_sel_i[0]) begin
				if (idx == LOW_IDX[c]) begin
					low_temp_limit_reg[c] <= wb_dat_i[TW-1:0];
				end
				if (idx == HIGH_IDX[c]) begin
					high_temp_limit_reg[c] <= wb_dat_i[TW-1:0];
				end
				if (idx == CRIT_IDX[c]) begin
					critical_temp_limit_reg[c] <= wb_dat_i[TW-1:0];
				end
				if (idx == SPAN_IDX[c]) begin
					duty_slope_span_reg[c] <= wb_dat_i[TW-1:0];
				end
			end
		end
	end

	// Control, cycle codes and hysteresis
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= CTRL_RST;
			cyc_reg <= CYC_RST;
			hya_reg <= HYA_RST;
			hyb_reg <= HYB_RST;
		end else if (wr) begin
			if (idx == CTRL_IDX && wb_sel_i[0]) begin
				ctrl_reg <= wb_dat_i[2:0];
			end
			if (idx == CYC_IDX && wb_sel_i[0]) begin
				cyc_reg[7:0] <= wb_dat_i[7:0];
			end
			if (idx == CYC_IDX && wb_sel_i[1]) begin
				cyc_reg[8] <= wb_dat_i[8];
			end
			if (idx == HYA_IDX && wb_sel_i[0]) begin
				hya_reg <= wb_dat_i[7:0];
			end
			if (idx == HYB_IDX && wb_sel_i[0]) begin
				hyb_reg <= {wb_dat_i[7:4], 4'h0};
			end
		end
	end

	// Limit flags: sticky, write one to clear, a new event beats the clear
	always_comb begin
		stat_set = 9'h000;
		for (int c = 0; c < NCH; c++) begin
			stat_set[c] = temp_valid_i && (tint[c] < low_temp_limit_reg[c]);
			stat_set[3+c] = temp_valid_i && (tint[c] > high_temp_limit_reg[c]);
			stat_set[6+c] = temp_valid_i && (tint[c] > critical_temp_limit_reg[c]);
		end
		stat_clr = 9'h000;
		if (wr && idx == STAT_IDX) begin
			stat_clr[7:0] = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
			stat_clr[8] = wb_sel_i[1] && wb_dat_i[8];
		end
		stat_next = (stat_reg & ~stat_clr) | stat_set;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_reg <= STAT_RST;
		end else begin
			stat_reg <= stat_next;
		end
	end

	// Critical hold: stays at full duty until below limit minus hysteresis
	always_ff @(posedge clk_i) begin
		for (int c = 0; c < NCH; c++) begin
			if (rst_i) begin
				crit_act_reg[c] <= 1'b0;
			end else if (temp_valid_i && tint[c] > critical_temp_limit_reg[c]) begin
				crit_act_reg[c] <= 1'b1;
			end else if (temp_valid_i && tint[c] < crit_band[c]) begin
				crit_act_reg[c] <= 1'b0;
			end
		end
	end
	assign full_speed_o = |crit_act_reg;

	// Fan-on level per zone, refreshed every clock
	always_ff @(posedge clk_i) begin
		for (int c = 0; c < NCH; c++) begin
			if (rst_i) begin
				fan_on_reg[c] <= 1'b0;
			end else begin
				fan_on_reg[c] <= tint[c] >= thr[c];
			end
		end
	end
	assign fan_on_o = fan_on_reg;

	for (genvar c = 0; c < NCH; c++) begin : g_ch
		assign tint[c] = temp[c][TW+1:FW];
		assign crit_band[c] = (critical_temp_limit_reg[c] > TW'(hy[c]))
			? critical_temp_limit_reg[c] - TW'(hy[c]) : '0;
		assign thr_wr[c] = wr && wb_sel_i[0] && idx == THR_IDX[c];

		fdt_cycle_timer #(
			.CW(CODE_W),
			.NW(CNT_W)
		) u_timer (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.mon_i(temp_valid_i),
			.code_i(cyc_reg[3*c +: 3]),
			.short_o(short_tick[c]),
			.long_o(long_tick[c])
		);

		// Independent loop per zone
		fdt_chan_loop #(
			.TW(TW)
		) u_loop (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.mon_i(temp_valid_i),
			.short_i(short_tick[c]),
			.long_i(long_tick[c]),
			.en_i(ctrl_reg[c]),
			.temp_i(temp[c]),
			.target_i(tgt_reg[c]),
			.hyst_i(hy[c]),
			.low_i(low_temp_limit_reg[c]),
			.wr_i(thr_wr[c]),
			.wr_data_i(wb_dat_i[TW-1:0]),
			.thr_o(thr[c])
		);

		low_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
			temp_valid_i && tint[c] < low_temp_limit_reg[c] |=> stat_reg[c])
			else $error("Low limit flag not set");
		high_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
			temp_valid_i && tint[c] > high_temp_limit_reg[c] |=> stat_reg[3+c])
			else $error("High limit flag not set");
		crit_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
			temp_valid_i && tint[c] > critical_temp_limit_reg[c]
			|=> full_speed_o && stat_reg[6+c])
			else $error("Critical limit did not force full duty");
		fan_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
			!rst_i && tint[c] < thr[c] |=> !fan_on_o[c])
			else $error("Fan on below start threshold");
		tgt_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
			$past(rst_i) |-> tgt_reg[c] == TGT_RST)
			else $error("Target reset value wrong");
	end

	assign remote1_fan_start_threshold_o = thr[0];
	assign local_fan_start_threshold_o = thr[1];
	assign remote2_fan_start_threshold_o = thr[2];
	assign remote1_duty_slope_span_o = duty_slope_span_reg[0];
	assign local_duty_slope_span_o = duty_slope_span_reg[1];
	assign remote2_duty_slope_span_o = duty_slope_span_reg[2];

	sequence bus_req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence

	sequence ack_pulse_s;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_req_s |=> ack_pulse_s)
		else $error("Bus ack not a single pulse");

	tgt_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && wb_sel_i[0] && idx == TGT_IDX[1]
		|=> tgt_reg[1] == $past(wb_dat_i[TW-1:0]))
		else $error("Target write lost");

	stat_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		stat_set[0] && stat_clr[0] |=> stat_reg[0])
		else $error("Flag set lost to clear");
endmodule

/* shared/fdt_pkg.sv */
/*
 Shared constants for the dynamic fan-start threshold loop: register
 indices, reset values and loop figures. Assumes a Wishbone word bus where
 the byte address of a register is four times its index.
*/
package fdt_pkg;
	localparam int NCH = 3;
	localparam int TW = 8;
	localparam int FW = 2;
	localparam int CODE_W = 3;
	localparam int CNT_W = 11;
	localparam int ADR_W = 32;
	localparam int IDX_W = 7;
	localparam int IDX_LSB = 2;
	localparam int SHORT_LOG2 = 3;
	localparam int LONG_LOG2 = 4;
	localparam int RISE_MIN_Q = 2;
	localparam logic [IDX_W-1:0] TGT_IDX [NCH] = '{7'h33, 7'h34, 7'h35};
	localparam logic [IDX_W-1:0] CTRL_IDX = 7'h36;
	localparam logic [IDX_W-1:0] CYC_IDX = 7'h37;
	localparam logic [IDX_W-1:0] STAT_IDX = 7'h38;
	localparam logic [IDX_W-1:0] LOW_IDX [NCH] = '{7'h4E, 7'h50, 7'h52};
	localparam logic [IDX_W-1:0] HIGH_IDX [NCH] = '{7'h4F, 7'h51, 7'h53};
	localparam logic [IDX_W-1:0] SPAN_IDX [NCH] = '{7'h5F, 7'h60, 7'h61};
	localparam logic [IDX_W-1:0] THR_IDX [NCH] = '{7'h67, 7'h68, 7'h69};
	localparam logic [IDX_W-1:0] CRIT_IDX [NCH] = '{7'h6A, 7'h6B, 7'h6C};
	localparam logic [IDX_W-1:0] HYA_IDX = 7'h6D;
	localparam logic [IDX_W-1:0] HYB_IDX = 7'h6E;
	localparam logic [7:0] TGT_RST = 8'hA4;
	localparam logic [7:0] LOW_RST = 8'h01;
	localparam logic [7:0] HIGH_RST = 8'h7F;
	localparam logic [7:0] CRIT_RST = 8'hA4;
	localparam logic [7:0] SPAN_RST = 8'h00;
	localparam logic [7:0] THR_RST = 8'h80;
	localparam logic [7:0] HYA_RST = 8'h44;
	localparam logic [7:0] HYB_RST = 8'h40;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [8:0] CYC_RST = 9'h000;
	localparam logic [8:0] STAT_RST = 9'h000;
endpackage

/* tb/fdt_dyn_thresh_tb.sv */
/*
 Self-checking bench for the dynamic fan-start threshold loop.
 Assumes the Wishbone slave answers with one wait state and that the loop
 pulse counter starts at reset, so pulses are counted from the first one.
*/
`timescale 1ns/10ps
module fdt_dyn_thresh_tb;
	import fdt_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0] sel = 4'h0;
	logic [ADR_W-1:0] adr = '0;
	logic [31:0] dat = 32'h0000_0000, dat_o, q;
	logic ack, tv, req = 1'b0, full;
	logic [9:0] t1 = 10'h000, t2 = 10'h000, t3 = 10'h000, s1, s2, s3;
	logic [7:0] th1, th2, th3, sp1, sp2, sp3;
	logic [2:0] fan;
	int errors = 0, tests_run = 0, cycles = 0;
	localparam logic [9:0] T_HI = {8'h98, 2'b00};
	localparam logic [9:0] T_UP = {8'h9A, 2'b00};
	localparam logic [9:0] T_LO = {8'h10, 2'b00};

	always #2.5 clk_i = ~clk_i;

	fdt_sensor_model fdt_sensor_model_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
		.r1_i(t1), .loc_i(t2), .r2_i(t3), .valid_o(tv), .r1_o(s1), .loc_o(s2), .r2_o(s3));

	fdt_dyn_thresh fdt_dyn_thresh_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .temp_valid_i(tv), .remote1_temp_i(s1),
		.local_temp_i(s2), .remote2_temp_i(s3), .remote1_fan_start_threshold_o(th1),
		.local_fan_start_threshold_o(th2), .remote2_fan_start_threshold_o(th3),
		.remote1_duty_slope_span_o(sp1), .local_duty_slope_span_o(sp2),
		.remote2_duty_slope_span_o(sp3), .fan_on_o(fan), .full_speed_o(full));

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Hang guard: whole run needs well under a thousand cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			stop_test();
		end
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [IDX_W-1:0] idx, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hF;
		adr <= ADR_W'({idx, 2'b00});
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		// Write lands on the ack edge; outputs settle one edge later
		@(posedge clk_i);
	endtask

	task automatic rd(input string name, input logic [IDX_W-1:0] idx, input logic [31:0] exp);
		wb(1'b0, idx, 32'h0000_0000);
		chk(name, q, exp);
	endtask

	// n monitoring pulses, all channels at the same temperature
	task automatic mon(input int n, input logic [9:0] t);
		t1 <= t;
		t2 <= t;
		t3 <= t;
		repeat (n) begin
			@(posedge clk_i);
			req <= 1'b1;
			@(posedge clk_i);
			req <= 1'b0;
			@(posedge clk_i);
		end
		repeat (3) @(posedge clk_i);
	endtask

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < NCH; i++) begin
			rd("target reset", TGT_IDX[i], 32'h0000_00A4);
		end
		chk("thr reset", {th1, th2, th3}, 24'h80_8080);
		wb(1'b1, TGT_IDX[1], 32'h0000_015A);
		rd("local target", TGT_IDX[1], 32'h0000_005A);
		rd("r2 target", TGT_IDX[2], 32'h0000_00A4);
		wb(1'b1, 7'h10, 32'h0000_00FF);
		rd("unmapped", 7'h10, 32'h0000_0000);
		wb(1'b1, SPAN_IDX[1], 32'h0000_0033);
		chk("span out", {sp1, sp2, sp3}, 24'h00_3300);
		rd("cycle codes", CYC_IDX, 32'h0000_0000);
		wb(1'b1, TGT_IDX[0], 32'h0000_0090);
		wb(1'b1, LOW_IDX[0], 32'h0000_0020);
		// Loop parameters first, enable last
		wb(1'b1, CTRL_IDX, 32'h0000_0001);
		mon(8, T_HI);
		chk("short no rise", th1, 8'h80);
		mon(8, T_HI);
		chk("long above", th1, 8'h7F);
		chk("disabled chans", {th2, th3}, 16'h8080);
		mon(7, T_HI);
		mon(1, T_UP);
		chk("short rise", th1, 8'h7B);
		mon(7, T_UP);
		mon(1, T_UP | 10'h001);
		chk("quarter rise", th1, 8'h7A);
		rd("high flags", STAT_IDX, 32'h0000_0038);
		wb(1'b1, STAT_IDX, 32'h0000_01FF);
		rd("flags cleared", STAT_IDX, 32'h0000_0000);
		mon(8, T_LO);
		chk("short no raise", th1, 8'h7A);
		chk("fans off", fan, 3'b000);
		mon(8, T_LO);
		chk("long raise", th1, 8'h7B);
		rd("low flag", STAT_IDX, 32'h0000_0001);
		wb(1'b1, THR_IDX[0], 32'h0000_0002);
		mon(7, T_LO);
		mon(1, T_UP);
		chk("floor", th1, 8'h00);
		chk("fans on", fan, 3'b111);
		mon(1, {8'hA8, 2'b00});
		chk("full speed", full, 1'b1);
		rd("crit flags", STAT_IDX, 32'h0000_01F9);
		chk("no tick", th1, 8'h00);
		// Local zone alone, code 1: short every 16, long every 32 pulses
		wb(1'b1, CYC_IDX, 32'h0000_0008);
		wb(1'b1, CTRL_IDX, 32'h0000_0002);
		mon(7, T_HI);
		chk("local long", {th1, th2, th3}, 24'h00_7F80);
		chk("full released", full, 1'b0);
		mon(16, T_HI);
		chk("local code one", th2, 8'h7F);
		stop_test();
	end
endmodule

/* tb/fdt_sensor_model.sv */
/*
 Model of the temperature measurement side: one valid pulse per monitoring
 cycle with three raw temperature codes. Assumes the bench asks for each
 sample with a one-cycle request and never repeats a request back to back.
*/
`timescale 1ns/10ps
module fdt_sensor_model (
	input logic clk_i,
	input logic rst_i,
	input logic req_i,
	input logic [9:0] r1_i,
	input logic [9:0] loc_i,
	input logic [9:0] r2_i,
	output logic valid_o,
	output logic [9:0] r1_o,
	output logic [9:0] loc_o,
	output logic [9:0] r2_o
);
	// Samples held between pulses, as a real converter result register would
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
			r1_o <= 10'h000;
			loc_o <= 10'h000;
			r2_o <= 10'h000;
		end else begin
			valid_o <= req_i;
			if (req_i) begin
				r1_o <= r1_i;
				loc_o <= loc_i;
				r2_o <= r2_i;
			end
		end
	end
endmodule
